// >>> hdl/dpg_gpio.sv
`timescale 1ns/1ns
// Behaviour
// RQ1: Sixteen I/O pins form two eight-bit ports, one bit per pin.
// RQ2: Each port has its own data, direction and attribute settings.
// RQ3: At attribute 0 an input pulls low only on data 0; outputs drive data.
// RQ4: After reset all pins are inputs with both direction registers zero.
// RQ5: The first port direction register is write-only and resets to 00h.
// RQ6: Reading the capture register latches the second port pins.
// RQ7: A second port key change is one of four sources ending stop-clock.
// RQ8: Pin direction, attribute and level hold through stop and wake.
// RQ9: Attribute bits select general I/O when 0, grouped per pin group.
// RQ10: The second port direction register sets 0 input, 1 output, reset 0.
// RQ11: Data reads return pin level for inputs, driven value for outputs.
module dpg_gpio
#(
    parameter int unsigned PORT_W = 8 // RQ1
)
(
    input  wire logic              sys_clk_i,
    input  wire logic              reset_i,
    input  wire logic [7:0]        cpu_addr_i,
    input  wire logic [7:0]        cpu_wdata_i,
    input  wire logic              cpu_wr_i,
    input  wire logic              cpu_rd_i,
    output logic      [7:0]        cpu_rdata_o,
    input  wire logic [3:1]        timer_wake_i,
    output logic                   stop_clock_o,
    output logic                   wake_o,
    input  wire logic [PORT_W-1:0] port_c_pins_i,
    output logic      [PORT_W-1:0] port_c_pins_o,
    output logic      [PORT_W-1:0] port_c_pins_oe_o,
    output logic      [PORT_W-1:0] port_c_pull_low_o,
    input  wire logic [PORT_W-1:0] port_e_pins_i,
    output logic      [PORT_W-1:0] port_e_pins_o,
    output logic      [PORT_W-1:0] port_e_pins_oe_o,
    output logic      [PORT_W-1:0] port_e_pull_low_o
);

    logic [PORT_W-1:0]               first_port_direction_q;
    logic [PORT_W-1:0]               second_port_direction_q;
    logic [PORT_W-1:0]               first_port_out_q;
    logic [PORT_W-1:0]               second_port_out_q;
    logic [dpg_pkg::ATTR_USED_W-1:0] attr_q;
    logic [dpg_pkg::WAKE_SRC_W-1:0]  wake_en_q;
    logic [PORT_W-1:0]               second_port_input_capture_q;
    logic [PORT_W-1:0]               second_port_prev_q;
    logic [7:0]                      rdata_q;
    logic                            wake_q;
    dpg_pkg::dpg_state_t             state_q;

    wire sel_cdir  = cpu_addr_i == dpg_pkg::FIRST_PORT_DIRECTION_ADDR;
    wire sel_edir  = cpu_addr_i == dpg_pkg::SECOND_PORT_DIRECTION_ADDR;
    wire sel_cout  = cpu_addr_i == dpg_pkg::FIRST_PORT_OUT_DATA_ADDR;
    wire sel_edata = cpu_addr_i == dpg_pkg::SECOND_PORT_PIN_DATA_ADDR;
    wire sel_ecap  = cpu_addr_i == dpg_pkg::SECOND_PORT_INPUT_CAPTURE_ADDR;
    wire sel_cdata = cpu_addr_i == dpg_pkg::FIRST_PORT_PIN_DATA_ADDR;
    wire sel_attr  = cpu_addr_i == dpg_pkg::ATTRIBUTE_CTRL_ADDR;
    wire sel_wake  = cpu_addr_i == dpg_pkg::WAKEUP_CTRL_ADDR;
    wire sel_stop  = cpu_addr_i == dpg_pkg::STOP_CLOCK_ADDR;

    wire in_stop   = state_q == dpg_pkg::DPG_STOP;
    // Register writes are dropped while stopped, since the CPU is halted.
    wire wr_ok     = cpu_wr_i && !in_stop; // RQ8

    wire [PORT_W-1:0] c_attr;
    wire [PORT_W-1:0] e_attr;
    assign c_attr = {{4{attr_q[dpg_pkg::ATTR_PC_HI_BIT]}},
                     {4{attr_q[dpg_pkg::ATTR_PC_LO_BIT]}}}; // RQ9
    assign e_attr = {{4{attr_q[dpg_pkg::ATTR_PE_HI_BIT]}},
                     {2{attr_q[dpg_pkg::ATTR_PE_32_BIT]}},
                     attr_q[dpg_pkg::ATTR_PE_1_BIT],
                     attr_q[dpg_pkg::ATTR_PE_0_BIT]}; // RQ9

    // Attribute 1 is an undefined function, so those pins are left floating.
    genvar g;
    generate
        for (g = 0; g < PORT_W; g++)
        begin : g_pin
            assign port_c_pins_oe_o[g]  = !c_attr[g]
                                          && first_port_direction_q[g]; // RQ3
            assign port_c_pins_o[g]     = first_port_out_q[g]; // RQ3
            assign port_c_pull_low_o[g] = !c_attr[g] && !first_port_direction_q[g]
                                          && !first_port_out_q[g]; // RQ3
            assign port_e_pins_oe_o[g]  = !e_attr[g]
                                          && second_port_direction_q[g]; // RQ3
            assign port_e_pins_o[g]     = second_port_out_q[g]; // RQ3
            assign port_e_pull_low_o[g] = !e_attr[g] && !second_port_direction_q[g]
                                          && !second_port_out_q[g]; // RQ3
        end
    endgenerate

    wire [PORT_W-1:0] c_read;
    wire [PORT_W-1:0] e_read;
    assign c_read = (first_port_direction_q & first_port_out_q)
                  | (~first_port_direction_q & port_c_pins_i); // RQ11
    assign e_read = (second_port_direction_q & second_port_out_q)
                  | (~second_port_direction_q & port_e_pins_i); // RQ11

    wire [7:0] rd_mux;
    assign rd_mux = sel_cdata ? c_read :
                    sel_edata ? e_read :
                    sel_ecap  ? port_e_pins_i : // RQ6
                    sel_wake  ? {4'h0, wake_en_q} :
                    dpg_pkg::READ_UNMAPPED;

    // A key change is any edge on a second-port pin; only one while stopped can wake.
    wire key_change = |(port_e_pins_i ^ second_port_prev_q);
    wire [3:0] wake_src = {timer_wake_i, key_change};
    wire wake_hit = in_stop && |(wake_src & wake_en_q); // RQ7

    assign cpu_rdata_o  = rdata_q;
    assign stop_clock_o = in_stop;
    assign wake_o       = wake_q;

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            first_port_direction_q <= dpg_pkg::DIR_RESET; // RQ4 RQ5
            second_port_direction_q <= dpg_pkg::DIR_RESET; // RQ4 RQ10
            first_port_out_q       <= dpg_pkg::DATA_RESET;
            second_port_out_q       <= dpg_pkg::DATA_RESET;
            attr_q            <= dpg_pkg::ATTR_RESET[dpg_pkg::ATTR_USED_W-1:0];
            wake_en_q         <= dpg_pkg::WAKE_RESET[dpg_pkg::WAKE_SRC_W-1:0];
        end
        else if (wr_ok)
        begin
            if (sel_cdir)
                first_port_direction_q <= cpu_wdata_i; // RQ5
            if (sel_edir)
                second_port_direction_q <= cpu_wdata_i; // RQ10
            if (sel_cout)
                first_port_out_q <= cpu_wdata_i; // RQ2
            if (sel_edata)
                second_port_out_q <= cpu_wdata_i; // RQ11
            if (sel_attr)
                attr_q <= cpu_wdata_i[dpg_pkg::ATTR_USED_W-1:0]; // RQ9
            if (sel_wake)
                wake_en_q <= cpu_wdata_i[dpg_pkg::WAKE_SRC_W-1:0]; // RQ7
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
            second_port_input_capture_q <= dpg_pkg::DATA_RESET;
        else if (cpu_rd_i && sel_ecap)
            second_port_input_capture_q <= port_e_pins_i; // RQ6
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
            rdata_q <= dpg_pkg::READ_UNMAPPED;
        else if (cpu_rd_i)
            rdata_q <= rd_mux;
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_q      <= dpg_pkg::DPG_RUN;
            wake_q       <= 1'b0;
            second_port_prev_q <= dpg_pkg::DATA_RESET;
        end
        else
        begin
            second_port_prev_q <= port_e_pins_i;
            wake_q       <= 1'b0;
            case (state_q)
                dpg_pkg::DPG_RUN:
                    if (wr_ok && sel_stop)
                        state_q <= dpg_pkg::DPG_STOP;
                dpg_pkg::DPG_STOP:
                    if (wake_hit)
                    begin
                        state_q <= dpg_pkg::DPG_RUN; // RQ7
                        wake_q  <= 1'b1;
                    end
                default:
                    state_q <= dpg_pkg::DPG_RUN;
            endcase
        end
    end

    property p_cdir_reset;
        @(posedge sys_clk_i) $fell(reset_i) |-> first_port_direction_q == 8'h00;
    endproperty
    a_cdir_reset: assert property (p_cdir_reset) // RQ4
        else $error("port c direction not cleared by reset");

    property p_cdir_write;
        @(posedge sys_clk_i) disable iff (reset_i)
        (cpu_wr_i && sel_cdir && !in_stop)
            |=> first_port_direction_q == $past(cpu_wdata_i);
    endproperty
    a_cdir_write: assert property (p_cdir_write) // RQ5
        else $error("port c direction write lost");

    property p_edir_write;
        @(posedge sys_clk_i) disable iff (reset_i)
        (cpu_wr_i && sel_edir && !in_stop)
            |=> second_port_direction_q == $past(cpu_wdata_i);
    endproperty
    a_edir_write: assert property (p_edir_write) // RQ10
        else $error("port e direction write lost");

    property p_capture;
        @(posedge sys_clk_i) disable iff (reset_i)
        (cpu_rd_i && sel_ecap)
            |=> second_port_input_capture_q == $past(port_e_pins_i);
    endproperty
    a_capture: assert property (p_capture) // RQ6
        else $error("port e capture missed");

    property p_drive;
        @(posedge sys_clk_i) disable iff (reset_i)
        (first_port_direction_q[PORT_W-1] && !c_attr[PORT_W-1])
            |-> port_c_pins_oe_o[PORT_W-1]
            && port_c_pins_o[PORT_W-1] == first_port_out_q[PORT_W-1]
            && !port_c_pull_low_o[PORT_W-1];
    endproperty
    a_drive: assert property (p_drive) // RQ3
        else $error("output pin not driven");

    property p_hold_stop;
        @(posedge sys_clk_i) disable iff (reset_i)
        in_stop |=> $stable(port_e_pins_oe_o) && $stable(port_c_pins_o)
            && $stable(port_c_pins_oe_o) && $stable(attr_q)
            && $stable(port_e_pins_o);
    endproperty
    a_hold_stop: assert property (p_hold_stop) // RQ8
        else $error("pin state changed in stop");

    property p_key_wake;
        @(posedge sys_clk_i) disable iff (reset_i)
        (in_stop && wake_en_q[0] && key_change) |=> wake_o && !stop_clock_o;
    endproperty
    a_key_wake: assert property (p_key_wake) // RQ7
        else $error("key change did not wake");

    property p_read_input;
        @(posedge sys_clk_i) disable iff (reset_i)
        (cpu_rd_i && sel_cdata) |=> cpu_rdata_o == $past(c_read);
    endproperty
    a_read_input: assert property (p_read_input) // RQ11
        else $error("port c read mismatch");

    c_stop: cover property (@(posedge sys_clk_i) $rose(stop_clock_o));
    c_wake: cover property (@(posedge sys_clk_i) wake_o);
    property p_edir_reset;
        @(posedge sys_clk_i)
        $fell(reset_i) |-> second_port_direction_q == dpg_pkg::DIR_RESET;
    endproperty
    a_edir_reset: assert property (p_edir_reset) // RQ10
        else $error("port e direction not cleared by reset");

    property p_pull_low;
        @(posedge sys_clk_i) disable iff (reset_i)
        (!e_attr[PORT_W-1] && !second_port_direction_q[PORT_W-1]
            && !second_port_out_q[PORT_W-1])
            |-> port_e_pull_low_o[PORT_W-1] && !port_e_pins_oe_o[PORT_W-1];
    endproperty
    a_pull_low: assert property (p_pull_low) // RQ3
        else $error("input pin lost its pull-low");

    property p_attr_c_hi;
        @(posedge sys_clk_i) disable iff (reset_i)
        attr_q[dpg_pkg::ATTR_PC_HI_BIT]
            |-> port_c_pins_oe_o[7:4] == 4'h0
            && port_c_pull_low_o[7:4] == 4'h0;
    endproperty
    a_attr_c_hi: assert property (p_attr_c_hi) // RQ9
        else $error("port c upper group not released by attribute");

    property p_attr_e_hi;
        @(posedge sys_clk_i) disable iff (reset_i)
        attr_q[dpg_pkg::ATTR_PE_HI_BIT]
            |-> port_e_pins_oe_o[7:4] == 4'h0
            && port_e_pull_low_o[7:4] == 4'h0;
    endproperty
    a_attr_e_hi: assert property (p_attr_e_hi) // RQ9
        else $error("port e upper group not released by attribute");

    property p_stop_enter;
        @(posedge sys_clk_i) disable iff (reset_i)
        (cpu_wr_i && sel_stop && !in_stop) |=> stop_clock_o && !wake_o;
    endproperty
    a_stop_enter: assert property (p_stop_enter) // RQ7
        else $error("stop write did not stop the clock");

    // Timer requests are levels, so one held over stop entry wakes at once.
    property p_timer_wake;
        @(posedge sys_clk_i) disable iff (reset_i)
        (in_stop && (timer_wake_i & wake_en_q[3:1]) != 3'h0)
            |=> wake_o && !stop_clock_o;
    endproperty
    a_timer_wake: assert property (p_timer_wake) // RQ7
        else $error("timer request did not wake");

    property p_stay_stopped;
        @(posedge sys_clk_i) disable iff (reset_i)
        (in_stop && !(wake_en_q[0] && key_change)
            && (timer_wake_i & wake_en_q[3:1]) == 3'h0)
            |=> stop_clock_o && !wake_o;
    endproperty
    a_stay_stopped: assert property (p_stay_stopped) // RQ7
        else $error("stop left without an enabled source");

    property p_wake_pulse;
        @(posedge sys_clk_i) disable iff (reset_i)
        wake_o |=> !wake_o;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) // RQ7
        else $error("wake pulse longer than one cycle");

    c_cap:  cover property (@(posedge sys_clk_i) cpu_rd_i && sel_ecap);
    c_key:  cover property (@(posedge sys_clk_i)
                            in_stop && wake_en_q[0] && key_change);

endmodule // dpg_gpio

// >>> hdl/dpg_pkg.sv
package dpg_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    localparam logic [7:0] FIRST_PORT_DIRECTION_ADDR     = 8'h01;
    localparam logic [7:0] SECOND_PORT_PIN_DATA_ADDR      = 8'h03;
    localparam logic [7:0] SECOND_PORT_INPUT_CAPTURE_ADDR = 8'h04;
    localparam logic [7:0] FIRST_PORT_PIN_DATA_ADDR      = 8'h05;
    localparam logic [7:0] FIRST_PORT_OUT_DATA_ADDR      = 8'h02;
    localparam logic [7:0] ATTRIBUTE_CTRL_ADDR      = 8'h06;
    localparam logic [7:0] WAKEUP_CTRL_ADDR         = 8'h08;
    localparam logic [7:0] STOP_CLOCK_ADDR          = 8'h09;
    localparam logic [7:0] SECOND_PORT_DIRECTION_ADDR     = 8'h0B;

    localparam logic [7:0] DIR_RESET   = 8'h00;
    localparam logic [7:0] DATA_RESET  = 8'h00;
    localparam logic [7:0] ATTR_RESET  = 8'h00;
    localparam logic [7:0] WAKE_RESET  = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    localparam int unsigned ATTR_PC_HI_BIT = 5;
    localparam int unsigned ATTR_PC_LO_BIT = 4;
    localparam int unsigned ATTR_PE_HI_BIT = 3;
    localparam int unsigned ATTR_PE_32_BIT = 2;
    localparam int unsigned ATTR_PE_1_BIT  = 1;
    localparam int unsigned ATTR_PE_0_BIT  = 0;
    localparam int unsigned ATTR_USED_W    = 6;

    localparam int unsigned WAKE_KEY_BIT    = 0;
    localparam int unsigned WAKE_TMBA_BIT   = 1;
    localparam int unsigned WAKE_T128_BIT   = 2;
    localparam int unsigned WAKE_TMBB_BIT   = 3;
    localparam int unsigned WAKE_SRC_W      = 4;

    typedef enum logic [1:0]
    {
        DPG_RUN   = 2'b01,
        DPG_STOP  = 2'b10
    } dpg_state_t;

endpackage

// >>> sim/dpg_pin_model.sv
`timescale 1ns/1ns
module dpg_pin_model
(
    input  wire logic       sys_clk_i,
    input  wire logic [7:0] pin_out_i,
    input  wire logic [7:0] pin_oe_i,
    input  wire logic [7:0] pull_low_i,
    input  wire logic [7:0] ext_val_i,
    input  wire logic [7:0] ext_en_i,
    output logic      [7:0] level_o
);
    logic [7:0] last_q = 8'h00;
    // A floating pin shows the inverse of the level it had while last
    // driven, so that a lost drive is never mistaken for the old value.
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pin_oe_i[i])
                level_o[i] = pin_out_i[i];
            else if (ext_en_i[i])
                level_o[i] = ext_val_i[i];
            else if (pull_low_i[i])
                level_o[i] = 1'b0;
            else
                level_o[i] = ~last_q[i];
        end
    end
    always @(posedge sys_clk_i)
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pin_oe_i[i] || ext_en_i[i] || pull_low_i[i])
                last_q[i] <= level_o[i];
        end
    end
endmodule // dpg_pin_model

// >>> sim/test_dual_port_gpio_with_key_wake.sv
`timescale 1ns/1ns
module test_dual_port_gpio_with_key_wake;
    logic       sys_clk_i = 1'b0;
    logic       reset_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [3:1] twake = 3'b000;
    logic [7:0] c_ext = 8'h00;
    logic [7:0] c_en = 8'h00;
    logic [7:0] e_ext = 8'h5A;
    logic [7:0] e_en = 8'hFF;
    logic [7:0] rdata, c_lvl, e_lvl, c_o, c_oe, c_pl, e_o, e_oe, e_pl;
    logic       stop, wake;
    int         fails = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    int         n;

    always #25 sys_clk_i = ~sys_clk_i;

    dpg_gpio dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .cpu_addr_i(addr), .cpu_wdata_i(wdata), .cpu_wr_i(wr),
        .cpu_rd_i(rd), .cpu_rdata_o(rdata), .timer_wake_i(twake),
        .stop_clock_o(stop), .wake_o(wake), .port_c_pins_i(c_lvl),
        .port_c_pins_o(c_o), .port_c_pins_oe_o(c_oe),
        .port_c_pull_low_o(c_pl), .port_e_pins_i(e_lvl),
        .port_e_pins_o(e_o), .port_e_pins_oe_o(e_oe),
        .port_e_pull_low_o(e_pl));
    dpg_pin_model u_pc (.sys_clk_i(sys_clk_i), .pin_out_i(c_o),
        .pin_oe_i(c_oe), .pull_low_i(c_pl), .ext_val_i(c_ext),
        .ext_en_i(c_en), .level_o(c_lvl));
    dpg_pin_model u_pe (.sys_clk_i(sys_clk_i), .pin_out_i(e_o),
        .pin_oe_i(e_oe), .pull_low_i(e_pl), .ext_val_i(e_ext),
        .ext_en_i(e_en), .level_o(e_lvl));

    task automatic report_and_stop;
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: byte %h not %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: flag %b not %b", $time, got, exp);
        end
    endtask

    task automatic clk1;
        @(posedge sys_clk_i);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        clk1();
        addr = a;
        wdata = d;
        wr = 1'b1;
        clk1();
        wr = 1'b0;
    endtask

    // Read data is registered, so it is compared just after the read edge.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        clk1();
        addr = a;
        rd = 1'b1;
        clk1();
        rd = 1'b0;
        chk8(rdata, exp);
    endtask

    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            report_and_stop();
        end
    end

    initial
    begin
        repeat (3) clk1();
        reset_i = 1'b0;
        chk8(c_oe, 8'h00);
        chk8(e_oe, 8'h00);
        chk8(c_pl, 8'hFF);
        c_ext = 8'h96;
        c_en = 8'hFF;
        rd_chk(dpg_pkg::FIRST_PORT_PIN_DATA_ADDR, 8'h96);
        rd_chk(dpg_pkg::FIRST_PORT_DIRECTION_ADDR, 8'h00);
        rd_chk(8'h7F, dpg_pkg::READ_UNMAPPED);
        c_en = 8'h0F;
        wr_reg(dpg_pkg::FIRST_PORT_DIRECTION_ADDR, 8'hF0);
        wr_reg(dpg_pkg::FIRST_PORT_OUT_DATA_ADDR, 8'hA5);
        chk8(c_oe, 8'hF0);
        chk8(c_o, 8'hA5);
        chk8(c_pl, 8'h0A);
        rd_chk(dpg_pkg::FIRST_PORT_PIN_DATA_ADDR, 8'hA6);
        e_en = 8'hF0;
        wr_reg(dpg_pkg::SECOND_PORT_DIRECTION_ADDR, 8'h0F);
        wr_reg(dpg_pkg::SECOND_PORT_PIN_DATA_ADDR, 8'h3C);
        chk8(e_oe, 8'h0F);
        chk8(e_pl, 8'hC0);
        chk8(c_oe, 8'hF0);
        rd_chk(dpg_pkg::SECOND_PORT_PIN_DATA_ADDR, 8'h5C);
        rd_chk(dpg_pkg::SECOND_PORT_INPUT_CAPTURE_ADDR, 8'h5C);
        wr_reg(dpg_pkg::ATTRIBUTE_CTRL_ADDR, 8'h01);
        chk8(e_oe, 8'h0E);
        wr_reg(dpg_pkg::ATTRIBUTE_CTRL_ADDR, 8'h20);
        chk8(c_oe, 8'h00);
        wr_reg(dpg_pkg::ATTRIBUTE_CTRL_ADDR, 8'h1E);
        chk8(e_oe, 8'h01);
        chk8(e_pl, 8'h00);
        chk8(c_pl, 8'h00);
        chk8(c_oe, 8'hF0);
        wr_reg(dpg_pkg::ATTRIBUTE_CTRL_ADDR, dpg_pkg::ATTR_RESET);
        chk8(c_oe, 8'hF0);
        // Each pass enables one wake source only, then fires that one.
        for (int k = 0; k < 4; k++)
        begin
            wr_reg(dpg_pkg::WAKEUP_CTRL_ADDR, 8'(1 << k));
            rd_chk(dpg_pkg::WAKEUP_CTRL_ADDR, 8'(1 << k));
            wr_reg(dpg_pkg::STOP_CLOCK_ADDR, 8'h00);
            chk1(stop, 1'b1);
            wr_reg(dpg_pkg::SECOND_PORT_DIRECTION_ADDR, 8'h00);
            chk8(e_oe, 8'h0F);
            chk1(wake, 1'b0);
            if (k == 0)
                e_ext = e_ext ^ 8'h80;
            else
                twake[k] = 1'b1;
            n = 0;
            while (wake !== 1'b1 && n < 8)
            begin
                clk1();
                n++;
            end
            chk1(wake, 1'b1);
            chk1(stop, 1'b0);
            chk8(e_o, 8'h3C);
            twake = 3'b000;
            clk1();
            chk1(wake, 1'b0);
            chk8(e_oe, 8'h0F);
        end
        reset_i = 1'b1;
        clk1();
        reset_i = 1'b0;
        chk8(c_oe, 8'h00);
        chk8(e_oe, 8'h00);
        chk8(e_pl, 8'hFF);
        report_and_stop();
    end
endmodule // test_dual_port_gpio_with_key_wake
